// ===== bench/ovpbo_plant.sv
// Flyback stage, auxiliary winding, feedforward pin and mains divider
module ovpbo_plant
    import ovpbo_pkg::*;
(
    input wire logic clk_i,
    input wire ovpbo_ctrl_s ctrl_i,
    input wire logic ovp_i,
    input wire logic spike_i,
    input wire logic ff_open_i,
    input wire logic [9:0] mains_i,
    output logic gate_off_o = 1'b0,
    output logic gate_on_o = 1'b0,
    output logic in_win_o = 1'b0,
    output ovpbo_sense_s sense_o = '0
);
    timeunit 1ns;
    timeprecision 1ns;
    int ph = 0;
    int vcc = 0;
    int feedforward_pin = 0;
    int m;
    always @(negedge clk_i) begin
        ph = ctrl_i.gate_enable ? (ph + 1) % 40 : 0;
        gate_on_o <= ph == 1;
        gate_off_o <= ph == 11;
        in_win_o <= ph inside {[31:37]};
        sense_o.aux_winding_sense <= (ovp_i && ph inside {[31:37]}) ||
            (spike_i && ph inside {[13:28]});
        vcc = ctrl_i.hv_gen_on ? vcc + 2 :
            (ctrl_i.gate_enable ? ((vcc < 128) ? vcc + 1 : 128) : vcc - 1);
        feedforward_pin = (ctrl_i.ff_source_on && ff_open_i) ? feedforward_pin + 1 : 0;
        m = mains_i - (ctrl_i.mains_sink_on ? 15 : 0);
        sense_o.feedforward_latch <= feedforward_pin >= 10;
        sense_o.mains_above_on <= m > 485;
        sense_o.mains_above_off <= m > 450;
        sense_o.supply_at_startup <= vcc >= 130;
        sense_o.supply_below_restart <= vcc < 50;
        sense_o.supply_below_uvlo <= vcc < 100;
    end
endmodule : ovpbo_plant

// ===== bench/ovpbo_props.sv
// Concurrent checks on the protection logic ports
module ovpbo_props
    import ovpbo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic gate_off_i,
    input wire logic gate_on_i,
    input wire ovpbo_sense_s sense_i,
    input wire ovpbo_ctrl_s ctrl_o,
    input wire logic [2:0] trip_count_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    logic [5:0] since_ff;
    always_ff @(posedge clk_i) begin
        if (rst_i || gate_off_i) begin
            since_ff <= 6'h00;
        end else if (since_ff != 6'h3f) begin
            since_ff <= since_ff + 6'h01;
        end
    end
    sequence s_confirm;
        $changed(trip_count_o) && trip_count_o == 3'h4;
    endsequence
    sequence s_ovp_off;
        !ctrl_o.gate_enable && ctrl_o.ff_source_on;
    endsequence
    chk_sink_tracks_fail: assert property (ctrl_o.mains_sink_on == ctrl_o.mains_fail_flag)
        else $error("sink differs from fail flag");
    chk_fail_gate_low: assert property (ctrl_o.mains_fail_flag |-> !ctrl_o.gate_enable)
        else $error("gate on during mains fail");
    chk_fail_ss_dis: assert property (ctrl_o.mains_fail_flag |-> ctrl_o.softstart_discharge)
        else $error("soft-start not discharged");
    chk_four_stop: assert property (s_confirm |=> s_ovp_off)
        else $error("no shutdown after four trips");
    chk_count_step: assert property (trip_count_o != $past(trip_count_o) |->
        trip_count_o == 3'h0 || trip_count_o == $past(trip_count_o) + 3'h1)
        else $error("trip count jumped");
    chk_trip_window: assert property (trip_count_o > $past(trip_count_o) |->
        since_ff inside {[6'h18:6'h1e]})
        else $error("trip counted outside window");
    chk_gate_fall: assert property ($fell(ctrl_o.gate_enable) |->
        ctrl_o.mains_fail_flag || $past(trip_count_o) == 3'h4)
        else $error("gate stopped without cause");
    chk_latch_set: assert property (ctrl_o.ff_source_on && sense_i.feedforward_latch &&
        sense_i.mains_above_off && !sense_i.supply_below_uvlo |=> ctrl_o.latched_off)
        else $error("latch not taken");
    chk_latch_clear: assert property (ctrl_o.latched_off && !sense_i.mains_above_off |=>
        !ctrl_o.latched_off)
        else $error("latch not cleared");
    chk_latch_alive: assert property (ctrl_o.latched_off && sense_i.mains_above_off &&
        !sense_i.supply_below_uvlo && !sense_i.supply_at_startup |=> ctrl_o.hv_gen_on)
        else $error("supply not kept alive while latched");
    chk_brown_trip: assert property (ctrl_o.gate_enable && !sense_i.mains_above_off |=>
        ctrl_o.mains_fail_flag)
        else $error("brownout missed");
endmodule : ovpbo_props
bind ovpbo_protect ovpbo_props props_u (.clk_i, .rst_i, .gate_off_i, .gate_on_i, .sense_i,
    .ctrl_o, .trip_count_o);

// ===== bench/ovpbo_protect_test.sv
// Self-checking bench of the protection logic
module ovpbo_protect_test
    import ovpbo_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ns;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic gate_off_i, gate_on_i, in_win, hit = 1'b0;
    logic overvoltage_protection = 1'b0, spike = 1'b0, ff_open = 1'b0;
    logic [9:0] mains = 10'h1d6;
    logic [2:0] trip_count_o;
    ovpbo_sense_s sense;
    ovpbo_ctrl_s ctrl;
    int err_count = 0, checked = 0, cycles = 0, exp_cnt = 0;
    always #50 clk_i = ~clk_i;
    ovpbo_protect dut_u (.clk_i, .rst_i, .gate_off_i, .gate_on_i, .sense_i(sense),
        .ctrl_o(ctrl), .trip_count_o);
    ovpbo_plant plant_u (.clk_i, .ctrl_i(ctrl), .ovp_i(overvoltage_protection), .spike_i(spike),
        .ff_open_i(ff_open), .mains_i(mains), .gate_off_o(gate_off_i),
        .gate_on_o(gate_on_i), .in_win_o(in_win), .sense_o(sense));
    task automatic print_verdict;
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    task automatic chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("FAIL %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask : chk
    task automatic wait_gate(input logic lvl);
        int n;
        n = 0;
        while (ctrl.gate_enable !== lvl && n < 600) begin
            @(negedge clk_i);
            n++;
        end
        chk("gate_enable", {3'h0, ctrl.gate_enable}, {3'h0, lvl});
    endtask : wait_gate
    task automatic trips(input logic ffo, input string nm);
        ff_open = ffo;
        @(posedge gate_on_i);
        overvoltage_protection = 1'b1;
        wait_gate(1'b0);
        overvoltage_protection = 1'b0;
        chk("trip_count", {1'b0, trip_count_o}, 4'h4);
        chk("ff_source_on", {3'h0, ctrl.ff_source_on}, 4'h1);
        repeat (40) @(negedge clk_i);
        chk("latched_off", {3'h0, ctrl.latched_off}, {3'h0, ffo});
        $display("test %s done", nm);
    endtask : trips
    always @(negedge clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            print_verdict();
        end
        if (rst_i || !ctrl.gate_enable) begin
            exp_cnt = 0;
            hit = 1'b0;
        end else begin
            hit = hit | (in_win & sense.aux_winding_sense);
            if (gate_on_i) begin
                exp_cnt = hit ? ((exp_cnt < 4) ? exp_cnt + 1 : 4) : 0;
                chk("trip_count", {1'b0, trip_count_o}, 4'(exp_cnt));
                hit = 1'b0;
            end
        end
    end
    initial begin
        void'($urandom(18));
        repeat (8) @(negedge clk_i);
        rst_i = 1'b0;
        repeat (100) @(negedge clk_i);
        chk("mains_fail_flag", {3'h0, ctrl.mains_fail_flag}, 4'h1);
        mains = 10'(520 + $urandom % 300);
        wait_gate(1'b1);
        spike = 1'b1;
        repeat (300) @(negedge clk_i);
        spike = 1'b0;
        chk("gate_enable", {3'h0, ctrl.gate_enable}, 4'h1);
        @(posedge gate_on_i);
        overvoltage_protection = 1'b1;
        repeat (3) @(posedge gate_on_i);
        overvoltage_protection = 1'b0;
        repeat (3) @(posedge gate_on_i);
        $display("test counter done");
        trips(1'b1, "latch");
        chk("supply_below_uvlo", {3'h0, sense.supply_below_uvlo}, 4'h0);
        mains = 10'(300 + $urandom % 140);
        repeat (3) @(negedge clk_i);
        chk("latched_off", {3'h0, ctrl.latched_off}, 4'h0);
        mains = 10'(520 + $urandom % 300);
        wait_gate(1'b1);
        trips(1'b0, "restart");
        wait_gate(1'b1);
        mains = 10'(300 + $urandom % 140);
        repeat (3) @(negedge clk_i);
        chk("mains_sink_on", {3'h0, ctrl.mains_sink_on}, 4'h1);
        chk("softstart_discharge", {3'h0, ctrl.softstart_discharge}, 4'h1);
        mains = 10'(520 + $urandom % 300);
        wait_gate(1'b1);
        $display("test brownout done");
        print_verdict();
    end
endmodule : ovpbo_protect_test

// ===== pkg/ovpbo_pkg.sv
// Constants and carrier types of the overvoltage and brownout protection logic
// Behaviour
// - Overvoltage comparator counts only in a 0.5 us window opening 2 us after turn-off.
// - Trip when auxiliary winding sense exceeds the 5 V reference inside the window.
// - Switching stops for overvoltage only after four consecutive tripped cycles.
// - Trip counter clears in any cycle whose window saw no trip.
// - Confirmed overvoltage shuts down and enables the 1 mA feedforward source.
// - Feedforward pin reaching 5 V plus two drops latches the device off.
// - Without latch, restart is allowed once supply has fallen below 5 V.
// - Mains-fail asserts if sense below 0.485 V before start or 0.45 V running.
// - While mains-fail is high, shut down, discharge soft-start, hold gate low.
// - Brownout shutdown does not latch; operation resumes on recovery.
// - When latched off, mains sense below 0.45 V clears the protection latch.
// - Latched-off state cycles the supply between start-up threshold and 0.5 V below; the logic turns hv_gen_on back on as soon as supply drops below start-up.
// - During brownout the start-up generator keeps running with no PWM; hv_gen_on stops at start-up and restarts only below restart level.
// - The 15 uA mains-sense sink is on exactly while mains-fail is high.
// - Protection latch clears on supply below undervoltage lockout threshold or on mains sense below 0.45 V.
package ovpbo_pkg;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 100;
    localparam int BLANK_DELAY_NS = 2000;
    localparam int WINDOW_LEN_NS = 500;
    localparam logic [4:0] BLANK_CYC =
        5'((BLANK_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [4:0] WINDOW_CYC = 5'(WINDOW_LEN_NS / CLK_PERIOD_NS);
    localparam logic [4:0] TIMER_RST = 5'h00;

    // ****************************************
    // Trip counter
    // ****************************************
    localparam logic [2:0] TRIP_TERMINAL = 3'h4;
    localparam logic [2:0] TRIP_RST = 3'h0;

    // ****************************************
    // Types
    // ****************************************
    typedef enum logic [1:0] {
        OVPBO_WAIT  = 2'b00,
        OVPBO_RUN   = 2'b01,
        OVPBO_OVP   = 2'b11,
        OVPBO_LATCH = 2'b10
    } ovpbo_state_e;

    typedef struct packed {
        logic aux_winding_sense;
        logic feedforward_latch;
        logic mains_above_on;
        logic mains_above_off;
        logic supply_at_startup;
        logic supply_below_restart;
        logic supply_below_uvlo;
    } ovpbo_sense_s;

    typedef struct packed {
        logic gate_enable;
        logic softstart_discharge;
        logic ff_source_on;
        logic mains_sink_on;
        logic hv_gen_on;
        logic mains_fail_flag;
        logic latched_off;
    } ovpbo_ctrl_s;

endpackage : ovpbo_pkg

// ===== rtl/ovpbo_protect.sv
// Overvoltage qualification and brownout sequencing top
module ovpbo_protect
    import ovpbo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic gate_off_i,
    input wire logic gate_on_i,
    input wire ovpbo_sense_s sense_i,
    output ovpbo_ctrl_s ctrl_o,
    output logic [2:0] trip_count_o
);

    // ****************************************
    // Window timer
    // ****************************************
    logic win_open;
    logic win_close;

    ovpbo_window u_window (
        .clk_i(clk_i),
        .rst_i(rst_i),
        .gate_off_i(gate_off_i),
        .gate_on_i(gate_on_i),
        .win_open_o(win_open),
        .win_close_o(win_close)
    );

    // ****************************************
    // Trip counting
    // ****************************************
    logic tripped_ff;
    logic [2:0] trip_ff;
    logic [2:0] nxt_trip;
    logic trip_seen;
    logic ovp_confirmed;

    function automatic logic [2:0] sat_inc(input logic [2:0] v);
        sat_inc = (v == TRIP_TERMINAL) ? v : 3'(v + 3'h1);
    endfunction : sat_inc

    assign trip_seen = tripped_ff || (win_open && sense_i.aux_winding_sense);
    assign nxt_trip = trip_seen ? sat_inc(trip_ff) : TRIP_RST;
    assign ovp_confirmed = (trip_ff == TRIP_TERMINAL);

    always_ff @(posedge clk_i) begin
        if (rst_i || win_close || gate_on_i) begin
            tripped_ff <= 1'b0;
        end else if (win_open && sense_i.aux_winding_sense) begin
            tripped_ff <= 1'b1;
        end
    end

    // ****************************************
    // Mains sense with hysteresis
    // ****************************************
    ovpbo_state_e state_ff;
    ovpbo_state_e nxt_state;
    logic fail_ff;
    logic nxt_fail;
    logic running;

    assign running = (state_ff == OVPBO_RUN);
    assign nxt_fail = running ? !sense_i.mains_above_off : !sense_i.mains_above_on;

    // ****************************************
    // Sequencer
    // ****************************************

    always_comb begin
        nxt_state = state_ff;
        case (state_ff)
            OVPBO_WAIT: begin
                if (!fail_ff && !nxt_fail) begin
                    nxt_state = OVPBO_RUN;
                end
            end
            OVPBO_RUN: begin
                if (nxt_fail) begin
                    nxt_state = OVPBO_WAIT;
                end else if (ovp_confirmed) begin
                    nxt_state = OVPBO_OVP;
                end
            end
            OVPBO_OVP: begin
                if (sense_i.feedforward_latch) begin
                    nxt_state = OVPBO_LATCH;
                end else if (sense_i.supply_below_restart) begin
                    nxt_state = OVPBO_WAIT;
                end
            end
            OVPBO_LATCH: begin
                if (sense_i.supply_below_uvlo || !sense_i.mains_above_off) begin
                    nxt_state = OVPBO_WAIT;
                end
            end
            default: begin
                nxt_state = OVPBO_WAIT;
            end
        endcase
    end

    // ****************************************
    // Supply cycling of the start-up generator
    // ****************************************
    logic hv_ff;
    logic nxt_hv;
    logic keep_alive;

    // Latched off: recharge at once below start-up so supply never reaches lockout
    assign keep_alive = sense_i.supply_below_restart || (nxt_state == OVPBO_LATCH);
    assign nxt_hv = sense_i.supply_at_startup ? 1'b0 :
                    (keep_alive ? 1'b1 : hv_ff);

    ovpbo_ctrl_s ctrl_ff;
    ovpbo_ctrl_s nxt_ctrl;
    logic nxt_run;

    assign nxt_run = (nxt_state == OVPBO_RUN);
    assign nxt_ctrl.gate_enable = nxt_run && !nxt_fail;
    assign nxt_ctrl.softstart_discharge = nxt_fail || (nxt_state == OVPBO_LATCH);
    assign nxt_ctrl.ff_source_on = (nxt_state == OVPBO_OVP);
    assign nxt_ctrl.mains_sink_on = nxt_fail;
    assign nxt_ctrl.hv_gen_on = nxt_run ? 1'b0 : nxt_hv;
    assign nxt_ctrl.mains_fail_flag = nxt_fail;
    assign nxt_ctrl.latched_off = (nxt_state == OVPBO_LATCH);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_ff <= OVPBO_WAIT;
            trip_ff <= TRIP_RST;
            fail_ff <= 1'b1;
            hv_ff <= 1'b1;
            ctrl_ff <= '0;
        end else begin
            state_ff <= nxt_state;
            trip_ff <= (win_close && running) ? nxt_trip :
                       (running ? trip_ff : TRIP_RST);
            fail_ff <= nxt_fail;
            hv_ff <= nxt_hv;
            ctrl_ff <= nxt_ctrl;
        end
    end

    assign ctrl_o = ctrl_ff;
    assign trip_count_o = trip_ff;

endmodule : ovpbo_protect

// ===== rtl/ovpbo_window.sv
// Blanking delay and sampling window timer after each gate turn-off
module ovpbo_window
    import ovpbo_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic gate_off_i,
    input wire logic gate_on_i,
    output logic win_open_o,
    output logic win_close_o
);

    logic [4:0] cnt_ff;
    logic active_ff;
    logic open_ff;
    logic close_ff;
    logic [4:0] nxt_cnt;
    logic at_open;
    logic at_close;

    assign at_open = active_ff && (cnt_ff == BLANK_CYC);
    assign at_close = active_ff && (cnt_ff == 5'(BLANK_CYC + WINDOW_CYC));
    assign nxt_cnt = gate_off_i ? TIMER_RST : 5'(cnt_ff + 5'h01);

    always_ff @(posedge clk_i) begin
        if (rst_i || gate_on_i) begin
            cnt_ff <= TIMER_RST;
            active_ff <= 1'b0;
            open_ff <= 1'b0;
            close_ff <= 1'b0;
        end else begin
            cnt_ff <= (gate_off_i || active_ff) ? nxt_cnt : cnt_ff;
            active_ff <= gate_off_i || (active_ff && !at_close);
            open_ff <= (open_ff || at_open) && !at_close && !gate_off_i;
            close_ff <= at_close && !gate_off_i;
        end
    end

    assign win_open_o = open_ff;
    assign win_close_o = close_ff;

endmodule : ovpbo_window
